// >>> hdl/nep_pkg.sv
// Purpose: constants and types for the NAND ECC, protection and power-up block
// Assumes: 20 MHz core clock, SPI front end delivers decoded commands
// Notes: byte columns follow the page cache layout
//
// Functional notes
// - ECC enable reads 1 after power-up and every reset.
// - Set-feature at B0h bit 4 turns ECC on (1) or off (0).
// - Program with ECC on computes parity over cached data before array write.
// - Page read with ECC on checks fetched data, fills cache, reports status.
// - Erased never-programmed page reads back ECC status 00 always.
// - Internal parity bytes 840h-87Fh are never host readable or writable.
// - Meta II of spares 0/1 and 2/3 share joint parity bytes.
// - With ECC on, host writes to meta II parity bytes are dropped.
// - Spare starts at 800h; 800h-802h is meta I and bad-block mark.
// - Protection register at feature A0h is read and written by host.
// - After power-up all three protection level bits are 1.
// - Write-disable bit set and write-protect low freezes protection bits.
// - Program or erase of locked block sets fail flag, block untouched.
// - Level, side and complement bits decode the locked block range.
// - Power-up and wake load block 0 page 0 into cache with ECC.
// - Six read-from-cache opcodes return cache bytes, boot page included.
// - Below write-inhibit supply the logic sits in reset, ignoring all.
// - Write enable, program and erase ignored for 5 ms after power-up.
// - Reads are served while the write-inhibit delay still runs.
// - Power-up lands in standby with write latch and busy cleared.
// - ECC status: 00 clean, 01 fixed, 10 uncorrectable, 11 eight fixed.
package nep_pkg;
    localparam logic [7:0] FA_PROT = 8'hA0;
    localparam logic [7:0] FA_FEAT = 8'hB0;
    localparam logic [7:0] FA_STAT = 8'hC0;
    localparam logic [7:0] OP_GETF = 8'h0F;
    localparam logic [7:0] OP_SETF = 8'h1F;
    localparam logic [7:0] OP_WRITE_ENABLE_COMMAND = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_PRD  = 8'h13;
    localparam logic [7:0] OP_PEX  = 8'h10;
    localparam logic [7:0] OP_ERS  = 8'hD8;
    localparam logic [7:0] PROT_MASK = 8'hBE;
    localparam logic [7:0] PROT_RST  = 8'h38;
    localparam int         PROT_WD   = 7;
    localparam int         FEAT_ECC  = 4;
    localparam logic [1:0] ECC_OK  = 2'h0;
    localparam logic [1:0] ECC_FIX = 2'h1;
    localparam logic [1:0] ECC_BAD = 2'h2;
    localparam logic [1:0] ECC_FX8 = 2'h3;
    localparam logic [11:0] COL_SPARE = 12'h800;
    localparam logic [11:0] COL_INT   = 12'h840;
    localparam logic [11:0] COL_LAST  = 12'h87F;
    localparam logic [11:0] COL_END   = 12'h880;
    localparam logic [11:0] COL_M2P   = 12'h80C;
    localparam logic [3:0]  SP_M2     = 4'h3;
    localparam logic [3:0]  SP_PAR    = 4'hC;
    localparam int PUW_MS  = 5;
    localparam int VSL_MS  = 1;
    localparam int CLK_KHZ = 20000;
    localparam int PUW_CYC = PUW_MS * CLK_KHZ;
    localparam int PUW_W   = 17;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00, ST_LOAD = 2'b01, ST_SCAN = 2'b11, ST_PWR = 2'b10
    } nep_state_t;
    // Any of the six read-from-cache opcodes
    function automatic logic nep_is_crd(input logic [7:0] op);
        return op inside {8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
    endfunction
    // Program-load family writes the cache
    function automatic logic nep_is_ld(input logic [7:0] op);
        return op inside {8'h02, 8'h32, 8'h84, 8'hC4, 8'h34, 8'h72};
    endfunction
    // Device-owned parity byte: internal region or meta II parity
    function automatic logic nep_ppos(input logic [11:0] c);
        return (c >= COL_INT) || (c >= COL_SPARE && c[3:0] >= SP_PAR);
    endfunction
endpackage

// >>> hdl/nep_core.sv
// Purpose: ECC over page cache, block lock decode, power-up autoload
// Assumes: array answers a read one cycle after arr_rd_out
// Notes: rst_in comes from the supply monitor
`timescale 1ns/100ps
module nep_core
    import nep_pkg::*;
#(
    parameter int PUW_CYCLES = PUW_CYC,
    parameter int ROW_W      = 18,
    parameter int BLK_W      = 12
)(
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             wp_n_in,
    input  wire logic             wake_in,
    input  wire logic             cmd_valid_in,
    input  wire logic [7:0]       cmd_op_in,
    input  wire logic [23:0]      cmd_addr_in,
    input  wire logic [7:0]       cmd_data_in,
    input  wire logic [7:0]       arr_rdata_in,
    output logic                  resp_valid_out,
    output logic [7:0]            resp_data_out,
    output logic                  oip_out,
    output logic                  arr_rd_out,
    output logic                  arr_wr_out,
    output logic                  arr_erase_out,
    output logic [ROW_W-1:0]      arr_row_out,
    output logic [11:0]           arr_col_out,
    output logic [7:0]            arr_wdata_out
);
    nep_state_t       st_reg, st_next;
    logic [11:0]      col_reg, col_next, dcol_reg, dcol_next;
    logic             dv_reg, dv_next;
    logic [ROW_W-1:0] row_reg, row_next;
    logic [3:0][7:0]  mp_reg, mp_next, m1_reg, m1_next;
    logic [1:0][7:0]  m2_reg, m2_next, cap_reg, cap_next;
    logic             mis_reg, mis_next, ff_reg, ff_next;
    logic [7:0]       prot_reg, prot_next;
    logic             ecc_reg, ecc_next;
    logic [1:0]       eccs_reg, eccs_next;
    logic             pf_reg, pf_next, ef_reg, ef_next;
    logic             wel_reg, wel_next, oip_reg, oip_next;
    logic             boot_reg, boot_next;
    logic [PUW_W-1:0] puw_reg, puw_next;
    logic             pok_reg, pok_next;
    logic             rv_reg, rv_next, hrd_reg, hrd_next, hz_reg, hz_next;
    logic [7:0]       rd_reg, rd_next;
    logic             ard_reg, ard_next, awr_reg, awr_next, aer_reg, aer_next;
    logic [11:0]      acol_reg, acol_next;
    logic [7:0]       awd_reg, awd_next;
    logic             wp_s1, wp_s2, wk_s1, wk_s2, wk_s3;
    logic [7:0]       cache_mem [0:2175];
    logic [7:0]       cache_q;
    logic             cwe;
    logic [11:0]      cwa, cra;
    logic [7:0]       cwd, b, pb;
    logic             lock, cmd, wake_rise;
    logic [3:0]       so;

    // Block lock decode; top region means highest block numbers
    function automatic logic prot_lock(input logic [7:0] p, input logic [BLK_W-1:0] blk);
        logic [2:0]       lv;
        logic [BLK_W-1:0] n;
        logic             base;
        lv   = p[5:3];
        n    = BLK_W'(1) << (BLK_W - 7 + int'(lv));
        base = p[2] ? (blk < n) : (blk >= BLK_W'(0) - n);
        if (lv == 3'h0)
            return 1'b0;
        if (lv == 3'h7)
            return 1'b1;
        if (p[1] && lv == 3'h6)
            return blk == '0;
        return p[1] ^ base;
    endfunction

    assign resp_valid_out = rv_reg;
    assign resp_data_out  = rd_reg;
    assign oip_out        = oip_reg;
    assign arr_rd_out     = ard_reg;
    assign arr_wr_out     = awr_reg;
    assign arr_erase_out  = aer_reg;
    assign arr_row_out    = row_reg;
    assign arr_col_out    = acol_reg;
    assign arr_wdata_out  = awd_reg;

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            {wp_s1, wp_s2, wk_s1, wk_s2, wk_s3} <= 5'h00;
        end
        else
        begin
            {wp_s1, wp_s2} <= {wp_n_in, wp_s1};
            {wk_s1, wk_s2, wk_s3} <= {wake_in, wk_s1, wk_s2};
        end
    end

    // Cache port select; one write and one read per cycle
    always_comb
    begin
        cra = (st_reg == ST_IDLE) ? cmd_addr_in[11:0] : col_reg;
        cwe = 1'b0;
        cwa = dcol_reg;
        cwd = arr_rdata_in;
        if (st_reg == ST_LOAD && dv_reg)
            cwe = 1'b1;
        else if (st_reg == ST_IDLE && cmd_valid_in && nep_is_ld(cmd_op_in) && !boot_reg)
        begin
            cwa = cmd_addr_in[11:0];
            cwd = cmd_data_in;
            // Internal bytes never, meta II parity only with ECC off
            cwe = cwa < COL_INT && !(ecc_reg && nep_ppos(cwa));
        end
    end

    // Cache array has no reset on purpose
    always_ff @(posedge core_clk_in)
    begin
        if (cwe)
            cache_mem[cwa] <= cwd;
        cache_q <= cache_mem[cra];
    end

    // Parity byte that the device owns at column dcol
    always_comb
    begin
        pb = 8'h00;
        if (dcol_reg >= COL_INT)
        begin
            if (dcol_reg[5:2] == 4'h0)
                pb = mp_reg[dcol_reg[1:0]];
            else if (dcol_reg[5:2] == 4'h1)
                pb = m1_reg[dcol_reg[1:0]];
        end
        else if (dcol_reg[3:0] == SP_PAR)
            pb = m2_reg[dcol_reg[5]];
    end

    // Control, feature registers and parity engine
    always_comb
    begin
        st_next = st_reg;
        {col_next, dcol_next, row_next} = {col_reg, dcol_reg, row_reg};
        {mp_next, m1_next, m2_next, cap_next} = {mp_reg, m1_reg, m2_reg, cap_reg};
        {mis_next, ff_next, prot_next, ecc_next} = {mis_reg, ff_reg, prot_reg, ecc_reg};
        {eccs_next, pf_next, ef_next, wel_next} = {eccs_reg, pf_reg, ef_reg, wel_reg};
        {oip_next, boot_next, rd_next, acol_next} = {oip_reg, boot_reg, rd_reg, acol_reg};
        awd_next = awd_reg;
        {dv_next, rv_next, hrd_next, hz_next} = 4'h0;
        {ard_next, awr_next, aer_next} = 3'h0;
        wake_rise = wk_s2 && !wk_s3;
        cmd  = cmd_valid_in && !boot_reg;
        lock = prot_lock(prot_reg, cmd_addr_in[ROW_W-1:ROW_W-BLK_W]);
        b    = (st_reg == ST_LOAD) ? arr_rdata_in : cache_q;
        so   = dcol_reg[3:0];
        // Write enable, program execute and erase wait out the supply settle time; program load and set-feature do not
        puw_next = pok_reg ? puw_reg : puw_reg + PUW_W'(1);
        pok_next = pok_reg || (puw_reg == PUW_W'(PUW_CYCLES - 1));
        if (hrd_reg)
        begin
            rv_next = 1'b1;
            rd_next = hz_reg ? 8'h00 : cache_q;
        end
        // Status reads stay open while busy
        if (cmd && cmd_op_in == OP_GETF)
        begin
            rv_next = 1'b1;
            case (cmd_addr_in[7:0])
                FA_PROT: rd_next = prot_reg;
                FA_FEAT: rd_next = 8'(ecc_reg) << FEAT_ECC;
                FA_STAT: rd_next = {2'h0, eccs_reg, pf_reg, ef_reg, wel_reg, oip_reg};
                default: rd_next = 8'h00;
            endcase
        end
        // Parity accumulate; main by sector, spare by field
        if (dv_reg && st_reg != ST_PWR)
        begin
            ff_next = ff_reg && (b == 8'hFF);
            if (dcol_reg < COL_SPARE)
                mp_next[dcol_reg[10:9]] = mp_reg[dcol_reg[10:9]] ^ b;
            else if (dcol_reg < COL_INT)
            begin
                if (so < SP_M2)
                    m1_next[dcol_reg[5:4]] = m1_reg[dcol_reg[5:4]] ^ b;
                else if (so < SP_PAR)
                    m2_next[dcol_reg[5]] = m2_reg[dcol_reg[5]] ^ b;
                else if (so == SP_PAR)
                    cap_next[dcol_reg[5]] = b;
            end
            else if (dcol_reg[5:3] == 3'h0)
                mis_next = mis_reg || (b != pb);
        end
        case (st_reg)
            ST_IDLE:
            begin
                if (boot_reg || wake_rise)
                begin
                    // Boot page comes up before any command other than get-feature is taken
                    boot_next = 1'b0;
                    st_next   = ST_LOAD;
                    row_next  = '0;
                end
                else if (cmd)
                begin
                    if (cmd_op_in == OP_SETF && cmd_addr_in[7:0] == FA_PROT)
                    begin
                        if (!(prot_reg[PROT_WD] && !wp_s2))
                            prot_next = cmd_data_in & PROT_MASK;
                    end
                    else if (cmd_op_in == OP_SETF && cmd_addr_in[7:0] == FA_FEAT)
                        ecc_next = cmd_data_in[FEAT_ECC];
                    else if (cmd_op_in == OP_WRITE_ENABLE_COMMAND && pok_reg)
                        wel_next = 1'b1;
                    else if (cmd_op_in == OP_WRDI)
                        wel_next = 1'b0;
                    else if (nep_is_crd(cmd_op_in))
                    begin
                        // Served even inside the settle time
                        hrd_next = 1'b1;
                        hz_next  = cmd_addr_in[11:0] >= COL_INT;
                    end
                    else if (cmd_op_in == OP_PRD)
                    begin
                        st_next  = ST_LOAD;
                        row_next = cmd_addr_in[ROW_W-1:0];
                    end
                    else if (cmd_op_in == OP_PEX && wel_reg && pok_reg)
                    begin
                        pf_next  = lock;
                        wel_next = 1'b0;
                        if (!lock)
                        begin
                            st_next  = ecc_reg ? ST_SCAN : ST_PWR;
                            row_next = cmd_addr_in[ROW_W-1:0];
                        end
                    end
                    else if (cmd_op_in == OP_ERS && wel_reg && pok_reg)
                    begin
                        ef_next  = lock;
                        wel_next = 1'b0;
                        aer_next = !lock;
                        row_next = cmd_addr_in[ROW_W-1:0];
                    end
                end
                if (st_next != ST_IDLE)
                begin
                    col_next = 12'h000;
                    {mp_next, m1_next, m2_next, cap_next} = '0;
                    mis_next = 1'b0;
                    ff_next  = 1'b1;
                    oip_next = 1'b1;
                    if (st_next == ST_LOAD)
                        eccs_next = ECC_OK;
                end
            end
            ST_LOAD:
            begin
                if (col_reg != COL_END)
                begin
                    ard_next  = 1'b1;
                    acol_next = col_reg;
                    col_next  = col_reg + 12'h001;
                end
                dv_next   = ard_reg;
                dcol_next = acol_reg;
                if (dv_reg && dcol_reg == COL_LAST)
                begin
                    st_next  = ST_IDLE;
                    oip_next = 1'b0;
                    // Erased page or ECC off reports clean
                    if (ff_next || !ecc_reg)
                        eccs_next = ECC_OK;
                    else if (mis_next || cap_next != m2_next)
                        eccs_next = ECC_BAD;
                    else
                        eccs_next = ECC_OK;
                end
            end
            ST_SCAN:
            begin
                // First pass only sums; meta II parity sits mid-stream
                if (col_reg != COL_INT)
                begin
                    dv_next  = 1'b1;
                    col_next = col_reg + 12'h001;
                end
                dcol_next = col_reg;
                if (dv_reg && dcol_reg == COL_INT - 12'h001)
                begin
                    st_next  = ST_PWR;
                    col_next = 12'h000;
                    dv_next  = 1'b0;
                end
            end
            ST_PWR:
            begin
                if (col_reg != COL_END)
                begin
                    dv_next  = 1'b1;
                    col_next = col_reg + 12'h001;
                end
                dcol_next = col_reg;
                if (dv_reg)
                begin
                    awr_next  = 1'b1;
                    acol_next = dcol_reg;
                    if (ecc_reg && nep_ppos(dcol_reg))
                        awd_next = pb;
                    else
                        awd_next = (dcol_reg >= COL_INT) ? 8'hFF : cache_q;
                    if (dcol_reg == COL_LAST)
                    begin
                        st_next  = ST_IDLE;
                        oip_next = 1'b0;
                    end
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    // Control registers; reset is the supply monitor
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_reg   <= ST_IDLE;
            {col_reg, dcol_reg, acol_reg} <= '0;
            row_reg  <= '0;
            {mp_reg, m1_reg, m2_reg, cap_reg} <= '0;
            {mis_reg, ff_reg, dv_reg} <= 3'h0;
            prot_reg <= PROT_RST;
            ecc_reg  <= 1'b1;
            eccs_reg <= ECC_OK;
            {pf_reg, ef_reg, wel_reg, oip_reg} <= 4'h0;
            boot_reg <= 1'b1;
            puw_reg  <= '0;
            pok_reg  <= 1'b0;
            {rv_reg, hrd_reg, hz_reg} <= 3'h0;
            {rd_reg, awd_reg} <= 16'h0000;
            {ard_reg, awr_reg, aer_reg} <= 3'h0;
        end
        else
        begin
            st_reg <= st_next;
            {col_reg, dcol_reg, acol_reg} <= {col_next, dcol_next, acol_next};
            {row_reg, mp_reg, m1_reg, m2_reg, cap_reg} <= {row_next, mp_next, m1_next, m2_next, cap_next};
            {mis_reg, ff_reg, dv_reg} <= {mis_next, ff_next, dv_next};
            {prot_reg, ecc_reg, eccs_reg} <= {prot_next, ecc_next, eccs_next};
            {pf_reg, ef_reg, wel_reg, oip_reg} <= {pf_next, ef_next, wel_next, oip_next};
            {boot_reg, puw_reg, pok_reg} <= {boot_next, puw_next, pok_next};
            {rv_reg, hrd_reg, hz_reg, rd_reg, awd_reg} <= {rv_next, hrd_next, hz_next, rd_next, awd_next};
            {ard_reg, awr_reg, aer_reg} <= {ard_next, awr_next, aer_next};
        end
    end

    a_write_enable_command_settle: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (st_reg == ST_IDLE && cmd && cmd_op_in == OP_WRITE_ENABLE_COMMAND && !pok_reg && !boot_reg && !wake_rise)
        |=> !wel_reg) else $error("write enable taken during settle time");
    a_prog_locked: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (st_reg == ST_IDLE && cmd && cmd_op_in == OP_PEX && wel_reg && pok_reg && lock && !wake_rise)
        |=> pf_reg && st_reg == ST_IDLE ##1 !awr_reg) else $error("locked program not refused");
    a_erase_locked: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (st_reg == ST_IDLE && cmd && cmd_op_in == OP_ERS && wel_reg && pok_reg && lock && !wake_rise)
        |=> ef_reg && !aer_reg) else $error("locked erase not refused");
    a_prot_frozen: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (cmd && cmd_op_in == OP_SETF && cmd_addr_in[7:0] == FA_PROT && prot_reg[PROT_WD] && !wp_s2)
        |=> $stable(prot_reg)) else $error("protection changed while frozen");
    a_int_hidden: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (hrd_reg && hz_reg) |=> rv_reg && rd_reg == 8'h00) else $error("internal parity byte exposed");
    a_erased_clean: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (st_reg == ST_LOAD && dv_reg && dcol_reg == COL_LAST && ff_reg && arr_rdata_in == 8'hFF)
        |=> eccs_reg == ECC_OK && !oip_reg) else $error("erased page reported error");
    a_meta2_parity: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (st_reg == ST_PWR && dv_reg && ecc_reg && dcol_reg == COL_M2P)
        |=> awr_reg && awd_reg == m2_reg[0]) else $error("meta II parity not substituted");
    a_boot_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (st_reg == ST_IDLE && boot_reg) |=> st_reg == ST_LOAD && row_reg == '0 && oip_reg ##1 ard_reg)
        else $error("boot page load did not start");
endmodule // nep_core

// >>> tb/nep_array_model.sv
// Purpose: behavioural page array behind the core
// Assumes: one byte read per cycle, data one cycle later
// Notes: flip_in corrupts read data on command of the bench
`timescale 1ns/100ps
module nep_array_model
#(
    parameter int ROW_W = 18
)(
    input  wire logic             clk_in,
    input  wire logic             rd_in,
    input  wire logic             wr_in,
    input  wire logic             erase_in,
    input  wire logic [ROW_W-1:0] row_in,
    input  wire logic [11:0]      col_in,
    input  wire logic [7:0]       wdata_in,
    input  wire logic             flip_in,
    output logic      [7:0]       rdata_out = 8'h00
);
    logic [7:0] mem [bit [ROW_W+11:0]];
    // Unwritten cells read FFh; idle bus shows inverse so stale data never passes
    always @(posedge clk_in)
    begin
        if (rd_in)
            rdata_out <= (mem.exists({row_in, col_in}) ? mem[{row_in, col_in}] : 8'hFF) ^ {7'h00, flip_in};
        else
            rdata_out <= ~rdata_out;
        if (wr_in)
            mem[{row_in, col_in}] = wdata_in;
        // Coarse erase: wipes all, bench erases before it programs
        if (erase_in)
            mem.delete();
    end
endmodule // nep_array_model

// >>> tb/testbench.sv
// Purpose: command-level bench for nep_core
// Assumes: write-inhibit delay shortened to 3000 cycles
// Notes: inputs change at falling edge
`timescale 1ns/100ps
module testbench;
    import nep_pkg::*;
    localparam logic [23:0] AP = {16'h0000, FA_PROT}, AF = {16'h0000, FA_FEAT}, AS = {16'h0000, FA_STAT};
    logic        clk = 0, rst = 1, wp_n = 1, wake = 0, flip = 0, cv = 0;
    logic [7:0]  op = 0, dat = 0, rdat, rdv, wd, v;
    logic [23:0] adr = 0;
    logic        rv, operation_in_progress, ar, aw, ae;
    logic [17:0] row;
    logic [11:0] col;
    int          n_mismatch = 0, cmp_count = 0;
    logic [7:0]  crd[6] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
    logic [7:0]  tp[9] = '{8'h08, 8'h08, 8'h0C, 8'h0C, 8'h32, 8'h32, 8'h0A, 8'h0A, 8'h00};
    logic [11:0] bk[9] = '{12'hFFF, 12'hFBF, 12'h000, 12'h040, 12'h000, 12'h001, 12'hFBF, 12'hFC0, 12'h000};
    logic        te[9] = '{1, 0, 1, 0, 1, 0, 1, 0, 0};
    nep_core #(.PUW_CYCLES(3000)) nep_core_inst (.core_clk_in(clk), .rst_in(rst), .wp_n_in(wp_n),
        .wake_in(wake), .cmd_valid_in(cv), .cmd_op_in(op), .cmd_addr_in(adr), .cmd_data_in(dat),
        .arr_rdata_in(rdat), .resp_valid_out(rv), .resp_data_out(rdv), .oip_out(operation_in_progress), .arr_rd_out(ar),
        .arr_wr_out(aw), .arr_erase_out(ae), .arr_row_out(row), .arr_col_out(col), .arr_wdata_out(wd));
    nep_array_model nep_array_model_inst (.clk_in(clk), .rd_in(ar), .wr_in(aw), .erase_in(ae), .row_in(row),
        .col_in(col), .wdata_in(wd), .flip_in(flip), .rdata_out(rdat));
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One-cycle command pulse, entered at a falling edge
    task automatic cmd(input logic [7:0] o, input logic [23:0] a, input logic [7:0] d);
        cv = 1;
        op = o;
        adr = a;
        dat = d;
        @(negedge clk);
        cv = 0;
    endtask
    // Extra cycle lets status land before the next query
    task automatic ex(input logic [7:0] o, input logic [23:0] a, input logic [7:0] d);
        cmd(o, a, d);
        @(negedge clk);
    endtask
    // Answer sampled at the lat-th falling edge after the taking edge; trailing cycle keeps cv from dropping and rising at once
    task automatic rdc(input logic [7:0] o, input logic [23:0] a, input int lat, input logic [7:0] m,
                       input logic [7:0] e);
        cmd(o, a, 8'h00);
        repeat (lat - 1) @(negedge clk);
        chk({7'h00, rv}, 8'h01);
        v = rdv;
        chk(v & m, e);
        @(negedge clk);
    endtask
    // Poll busy under a bound so a stuck core cannot hang the run
    task automatic idle();
        int k;
        k = 0;
        do
        begin
            rdc(OP_GETF, AS, 1, 8'h00, 8'h00);
            k++;
        end
        while (v[0] !== 1'b0 && k < 3000);
        if (k >= 3000)
            n_mismatch++;
        chk({7'h00, operation_in_progress}, 8'h00);
    endtask
    task automatic prog(input logic [23:0] a);
        ex(OP_WRITE_ENABLE_COMMAND, 24'h0, 8'h00);
        ex(OP_PEX, a, 8'h00);
        idle();
    endtask
    initial
    begin
        repeat (12) @(negedge clk);
        rst = 0;
        @(negedge clk);
        rdc(OP_GETF, AP, 1, 8'hFF, 8'h38);
        rdc(OP_GETF, AF, 1, 8'h10, 8'h10);
        rdc(OP_GETF, AS, 1, 8'h01, 8'h01);
        idle();
        rdc(OP_GETF, AS, 1, 8'hFF, 8'h00);
        foreach (crd[i]) rdc(crd[i], 24'h0, 2, 8'hFF, 8'hFF);
        rdc(8'h03, 24'h000840, 2, 8'hFF, 8'h00);
        ex(OP_WRITE_ENABLE_COMMAND, 24'h0, 8'h00);
        rdc(OP_GETF, AS, 1, 8'h02, 8'h00);
        repeat (1000) @(negedge clk);
        ex(OP_WRITE_ENABLE_COMMAND, 24'h0, 8'h00);
        ex(OP_PEX, 24'h0, 8'h00);
        rdc(OP_GETF, AS, 1, 8'h0B, 8'h08);
        ex(OP_SETF, AP, 8'hFF);
        rdc(OP_GETF, AP, 1, 8'hFF, 8'hBE);
        wp_n = 0;
        repeat (3) @(negedge clk);
        ex(OP_SETF, AP, 8'h00);
        rdc(OP_GETF, AP, 1, 8'hFF, 8'hBE);
        wp_n = 1;
        repeat (3) @(negedge clk);
        // Lock decode probed by erase outcome on both sides of each boundary
        for (int i = 0; i < 9; i++)
        begin
            ex(OP_SETF, AP, tp[i]);
            ex(OP_WRITE_ENABLE_COMMAND, 24'h0, 8'h00);
            ex(OP_ERS, {6'h00, bk[i], 6'h00}, 8'h00);
            rdc(OP_GETF, AS, 1, 8'h04, {5'h00, te[i], 2'h0});
        end
        ex(8'h02, 24'h0, 8'hAA);
        ex(8'h02, 24'h00080C, 8'h55);
        prog(24'h000040);
        ex(OP_PRD, 24'h000040, 8'h00);
        idle();
        rdc(OP_GETF, AS, 1, 8'h30, 8'h00);
        rdc(8'h03, 24'h0, 2, 8'hFF, 8'hAA);
        // Joint parity of erased meta II bytes of spares 0 and 1 is 00
        rdc(8'h03, 24'h00080C, 2, 8'hFF, 8'h00);
        chk({7'h00, v === 8'h55}, 8'h00);
        flip = 1;
        ex(OP_PRD, 24'h000040, 8'h00);
        idle();
        flip = 0;
        rdc(OP_GETF, AS, 1, 8'h30, 8'h20);
        ex(OP_SETF, AF, 8'h00);
        rdc(OP_GETF, AF, 1, 8'h10, 8'h00);
        ex(8'h02, 24'h00080C, 8'h55);
        prog(24'h000080);
        ex(OP_PRD, 24'h000080, 8'h00);
        idle();
        rdc(8'h03, 24'h00080C, 2, 8'hFF, 8'h55);
        wake = 1;
        repeat (4) @(negedge clk);
        rdc(OP_GETF, AS, 1, 8'h01, 8'h01);
        wake = 0;
        idle();
        rdc(8'h0B, 24'h0, 2, 8'hFF, 8'hFF);
        final_report();
    end
    // Watchdog well beyond the roughly 18600 cycles the tests need
    initial
    begin
        repeat (80000) @(negedge clk);
        n_mismatch++;
        final_report();
    end
endmodule // testbench
